/* File: design/psm_consts.svh */
// constants for the pin state manager
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
`define PSM_PIN_TRIES      2'h3
`define PSM_UNBLK_TRIES    4'hA
`define PSM_LC_PIN         8'h08
`define PSM_LC_UNBLK       8'h10
`define PSM_LC_EMPTY       8'h00
`define PSM_P1_PLAIN       8'h00
`define PSM_P1_RSVD        8'h01
`define PSM_P1_SUBST_BIT   7
`define PSM_REF_LSB        0
`define PSM_REF_MSB        4
`define PSM_RFU_MSB        6
`define PSM_RFU_LSB        5
`define PSM_USE_SUBST      8'h08
`define PSM_USE_NONE       8'h00
`define PSM_SW_OK          16'h9000
`define PSM_SW_TRIES       12'h63C
`define PSM_SW_BLOCKED     16'h6983
`define PSM_SW_COND        16'h6985
`define PSM_SW_LEN         16'h6700
`define PSM_SW_P1P2        16'h6A86
`define PSM_SW_REF         16'h6A88
`define PSM_NUM_PINS       4
`define PSM_IDX_W          2
`define PSM_PIN_W          64
`define PSM_BYTE_W         8
`define PSM_PIN_BYTES      8
`define PSM_RAM_WORDS      8
`define PSM_RAM_AW         3
`define PSM_PUK_BASE       3'h4
`endif

/* File: design/psm_pkg.sv */
// types for the pin state manager
package psm_pkg;
  typedef enum logic [1:0] {
    psm_op_disable,
    psm_op_enable,
    psm_op_unblock
  } psm_op_t;
  typedef enum logic [2:0] {
    psm_idle,
    psm_rd_pin,
    psm_wt_pin,
    psm_rd_puk,
    psm_wt_puk,
    psm_exec,
    psm_done
  } psm_state_t;
endpackage

/* File: design/psm_ram.sv */
// pin and unblock code value store, registered read
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_ram (
  input  wire logic                    clk_sys,
  input  wire logic                    clk_en,
  input  wire logic                    wr_en,
  input  wire logic [`PSM_RAM_AW-1:0]  wr_addr,
  input  wire logic [`PSM_PIN_W-1:0]   wr_data,
  input  wire logic [`PSM_RAM_AW-1:0]  rd_addr,
  output logic      [`PSM_PIN_W-1:0]   rd_data_ff
);
  logic [`PSM_PIN_W-1:0] mem_ff [`PSM_RAM_WORDS];
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: design/psm_cmp.sv */
// byte-wise comparison of a presented pin against the stored value
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_cmp (
  input  wire logic [`PSM_PIN_W-1:0] given,
  input  wire logic [`PSM_PIN_W-1:0] stored,
  output logic                       match
);
  logic [`PSM_PIN_BYTES-1:0] byte_eq;
  genvar gi;
  generate
    for (gi = 0; gi < `PSM_PIN_BYTES; gi++) begin : g_byte
      assign byte_eq[gi] = given[gi*`PSM_BYTE_W +: `PSM_BYTE_W] ==
                           stored[gi*`PSM_BYTE_W +: `PSM_BYTE_W];
    end
  endgenerate
  assign match = &byte_eq;
endmodule
`default_nettype wire

/* File: design/psm_top.sv */
// pin disable, enable and unblock command interpreter
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_top
  import psm_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        cmd_valid,
  input  wire psm_op_t                     cmd_op,
  input  wire logic [7:0]                  cmd_p1,
  input  wire logic [7:0]                  cmd_p2,
  input  wire logic [7:0]                  cmd_lc,
  input  wire logic [`PSM_PIN_W-1:0]       cmd_data_a,
  input  wire logic [`PSM_PIN_W-1:0]       cmd_data_b,
  output logic                             cmd_ready,
  input  wire logic                        nv_load,
  input  wire logic [`PSM_NUM_PINS*8-1:0]  nv_image_in,
  output logic      [`PSM_NUM_PINS*8-1:0]  nv_image_out,
  input  wire logic                        pin_wr_en,
  input  wire logic [`PSM_RAM_AW-1:0]      pin_wr_addr,
  input  wire logic [`PSM_PIN_W-1:0]       pin_wr_data,
  input  wire logic                        session_clr,
  output logic                             rsp_valid_ff,
  output logic [15:0]                      rsp_sw_ff,
  output logic [`PSM_NUM_PINS-1:0]         pin_enabled_ff,
  output logic [`PSM_NUM_PINS-1:0]         pin_blocked_ff,
  output logic [`PSM_NUM_PINS-1:0]         puk_blocked_ff,
  output logic [`PSM_NUM_PINS-1:0]         pin_verified_ff,
  output logic [`PSM_NUM_PINS-1:0]         access_granted,
  output logic                             any_disabled,
  output logic [7:0]                       subst_usage_ff,
  output logic [4:0]                       subst_ref_ff,
  output logic [`PSM_IDX_W-1:0]            subst_pin_ff,
  output logic                             subst_active_ff,
  output logic                             se_reeval_ff
);
  psm_state_t state_ff;
  psm_state_t nxt_state;
  psm_op_t    op_ff;
  logic [7:0] p1_ff;
  logic [`PSM_IDX_W-1:0] idx_ff;
  logic [`PSM_PIN_W-1:0] data_a_ff;
  logic [`PSM_PIN_W-1:0] data_b_ff;
  logic [1:0] pin_cnt_ff [`PSM_NUM_PINS];
  logic [3:0] puk_cnt_ff [`PSM_NUM_PINS];
  logic       pin_match_ff;
  logic       puk_match_ff;
  logic [`PSM_RAM_AW-1:0] rd_addr;
  logic [`PSM_PIN_W-1:0]  rd_data;
  logic                   ram_we;
  logic [`PSM_RAM_AW-1:0] ram_waddr;
  logic [`PSM_PIN_W-1:0]  ram_wdata;
  logic                   cmp_match;
  logic                   do_store;
  logic                   bad_ref;
  logic                   bad_p1;
  logic                   bad_len;
  logic [15:0]            sw_calc;
  logic [1:0]             pin_dec;
  logic [3:0]             puk_dec;
  logic [`PSM_IDX_W-1:0]  cmd_idx;
  logic [7:0]             cmd_lc_ff;
  logic [7:0]             p2_ff;

  assign cmd_idx = cmd_p2[`PSM_IDX_W-1:0];
  assign cmd_ready = (state_ff == psm_idle);

  psm_ram u_ram (
    .clk_sys    (clk_sys),
    .clk_en     (clk_en),
    .wr_en      (ram_we),
    .wr_addr    (ram_waddr),
    .wr_data    (ram_wdata),
    .rd_addr    (rd_addr),
    .rd_data_ff (rd_data)
  );

  psm_cmp u_cmp (
    .given  (data_a_ff),
    .stored (rd_data),
    .match  (cmp_match)
  );

  // pin value lives at idx, unblock code at idx plus base
  assign rd_addr = (state_ff == psm_rd_puk || state_ff == psm_wt_puk) ?
                   (`PSM_PUK_BASE | {1'b0, idx_ff}) : {1'b0, idx_ff};
  assign do_store = (state_ff == psm_exec) && (op_ff == psm_op_unblock) &&
                    (cmd_lc_ff == `PSM_LC_UNBLK) && puk_match_ff &&
                    !puk_blocked_ff[idx_ff];
  assign ram_we    = do_store || pin_wr_en;
  assign ram_waddr = do_store ? {1'b0, idx_ff} : pin_wr_addr;
  assign ram_wdata = do_store ? data_b_ff : pin_wr_data;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      op_ff     <= psm_op_disable;
      p1_ff     <= 8'h00;
      p2_ff     <= 8'h00;
      cmd_lc_ff <= 8'h00;
      idx_ff    <= '0;
      data_a_ff <= '0;
      data_b_ff <= '0;
    end else if (clk_en && cmd_valid && cmd_ready) begin
      op_ff     <= cmd_op;
      p1_ff     <= cmd_p1;
      p2_ff     <= cmd_p2;
      cmd_lc_ff <= cmd_lc;
      idx_ff    <= cmd_idx;
      data_a_ff <= cmd_data_a;
      data_b_ff <= cmd_data_b;
    end
  end

  // parameter checks on the latched command
  assign bad_ref = (p2_ff[`PSM_REF_MSB:`PSM_REF_LSB] == 5'h00) ||
                   (p2_ff[`PSM_RFU_MSB:`PSM_RFU_LSB] != 2'h0) ||
                   (p2_ff[`PSM_REF_MSB:`PSM_REF_LSB] > 5'(`PSM_NUM_PINS));
  always_comb begin
    bad_p1 = 1'b0;
    if (op_ff == psm_op_disable) begin
      bad_p1 = (p1_ff == `PSM_P1_RSVD) ||
               (p1_ff[`PSM_RFU_MSB:`PSM_RFU_LSB] != 2'h0) ||
               (p1_ff != `PSM_P1_PLAIN && !p1_ff[`PSM_P1_SUBST_BIT]) ||
               (p1_ff[`PSM_P1_SUBST_BIT] &&
                p1_ff[`PSM_REF_MSB:`PSM_REF_LSB] == 5'h00);
    end else if (op_ff == psm_op_enable) begin
      bad_p1 = (p1_ff != `PSM_P1_PLAIN);
    end else begin
      bad_p1 = (p1_ff != `PSM_P1_PLAIN);
    end
  end
  assign bad_len = (op_ff == psm_op_unblock) ?
                   (cmd_lc_ff != `PSM_LC_UNBLK && cmd_lc_ff != `PSM_LC_EMPTY) :
                   (cmd_lc_ff != `PSM_LC_PIN);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psm_idle:   if (cmd_valid) nxt_state = (cmd_op == psm_op_unblock) ? psm_rd_puk : psm_rd_pin;
      psm_rd_pin: nxt_state = psm_wt_pin;
      psm_wt_pin: nxt_state = psm_exec;
      psm_rd_puk: nxt_state = psm_wt_puk;
      psm_wt_puk: nxt_state = psm_exec;
      psm_exec:   nxt_state = psm_done;
      psm_done:   nxt_state = psm_idle;
      default:    nxt_state = psm_idle;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= psm_idle;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // result of the registered comparison, taken once read data has settled
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_match_ff <= 1'b0;
      puk_match_ff <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == psm_wt_pin) begin
        pin_match_ff <= cmp_match;
      end
      if (state_ff == psm_wt_puk) begin
        puk_match_ff <= cmp_match;
      end
    end
  end

  assign pin_dec = pin_cnt_ff[idx_ff] - 2'h1;
  assign puk_dec = puk_cnt_ff[idx_ff] - 4'h1;

  // status word of the command being executed
  always_comb begin
    sw_calc = `PSM_SW_OK;
    if (bad_ref) begin
      sw_calc = `PSM_SW_REF;
    end else if (bad_len) begin
      sw_calc = `PSM_SW_LEN;
    end else if (bad_p1) begin
      sw_calc = `PSM_SW_P1P2;
    end else begin
      case (op_ff)
        psm_op_disable: begin
          if (pin_blocked_ff[idx_ff] || !pin_enabled_ff[idx_ff]) begin
            sw_calc = `PSM_SW_COND;
          end else if (!pin_match_ff) begin
            sw_calc = (pin_dec == 2'h0) ? `PSM_SW_BLOCKED : {`PSM_SW_TRIES, 2'h0, pin_dec};
          end
        end
        psm_op_enable: begin
          if (pin_blocked_ff[idx_ff] || pin_enabled_ff[idx_ff]) begin
            sw_calc = `PSM_SW_COND;
          end else if (!pin_match_ff) begin
            sw_calc = (pin_dec == 2'h0) ? `PSM_SW_BLOCKED : {`PSM_SW_TRIES, 2'h0, pin_dec};
          end
        end
        psm_op_unblock: begin
          if (cmd_lc_ff == `PSM_LC_EMPTY) begin
            sw_calc = {`PSM_SW_TRIES, puk_cnt_ff[idx_ff]};
          end else if (puk_blocked_ff[idx_ff]) begin
            sw_calc = `PSM_SW_BLOCKED;
          end else if (!puk_match_ff) begin
            sw_calc = {`PSM_SW_TRIES, puk_dec};
          end
        end
        default: sw_calc = `PSM_SW_OK;
      endcase
    end
  end

  logic exec_ok;
  assign exec_ok = (state_ff == psm_exec) && !bad_ref && !bad_len && !bad_p1;

  // per-pin counters and states
  genvar gi;
  generate
    for (gi = 0; gi < `PSM_NUM_PINS; gi++) begin : g_pin
      logic sel;
      assign sel = exec_ok && (idx_ff == `PSM_IDX_W'(gi));
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          pin_cnt_ff[gi]     <= `PSM_PIN_TRIES;
          puk_cnt_ff[gi]     <= `PSM_UNBLK_TRIES;
          pin_enabled_ff[gi] <= 1'b1;
          pin_blocked_ff[gi] <= 1'b0;
          puk_blocked_ff[gi] <= 1'b0;
        end else if (clk_en && nv_load) begin
          pin_cnt_ff[gi]     <= nv_image_in[gi*8 +: 2];
          puk_cnt_ff[gi]     <= nv_image_in[gi*8+2 +: 4];
          pin_enabled_ff[gi] <= nv_image_in[gi*8+6];
          pin_blocked_ff[gi] <= nv_image_in[gi*8+7];
          puk_blocked_ff[gi] <= (nv_image_in[gi*8+2 +: 4] == 4'h0);
        end else if (clk_en && sel) begin
          case (op_ff)
            psm_op_disable: begin
              if (pin_enabled_ff[gi] && !pin_blocked_ff[gi]) begin
                if (pin_match_ff) begin
                  pin_cnt_ff[gi]     <= `PSM_PIN_TRIES;
                  pin_enabled_ff[gi] <= 1'b0;
                end else begin
                  pin_cnt_ff[gi] <= pin_dec;
                  if (pin_dec == 2'h0) begin
                    pin_blocked_ff[gi] <= 1'b1;
                  end
                end
              end
            end
            psm_op_enable: begin
              if (!pin_enabled_ff[gi] && !pin_blocked_ff[gi]) begin
                if (pin_match_ff) begin
                  pin_cnt_ff[gi]     <= `PSM_PIN_TRIES;
                  pin_enabled_ff[gi] <= 1'b1;
                end else begin
                  pin_cnt_ff[gi] <= pin_dec;
                  if (pin_dec == 2'h0) begin
                    pin_blocked_ff[gi] <= 1'b1;
                    pin_enabled_ff[gi] <= 1'b1;
                  end
                end
              end
            end
            psm_op_unblock: begin
              if (cmd_lc_ff == `PSM_LC_UNBLK && !puk_blocked_ff[gi]) begin
                if (puk_match_ff) begin
                  puk_cnt_ff[gi]     <= `PSM_UNBLK_TRIES;
                  pin_cnt_ff[gi]     <= `PSM_PIN_TRIES;
                  pin_enabled_ff[gi] <= 1'b1;
                  pin_blocked_ff[gi] <= 1'b0;
                end else begin
                  puk_cnt_ff[gi] <= puk_dec;
                  if (puk_dec == 4'h0) begin
                    puk_blocked_ff[gi] <= 1'b1;
                  end
                end
              end
            end
            default: pin_cnt_ff[gi] <= pin_cnt_ff[gi];
          endcase
        end
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          pin_verified_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          if (sel && op_ff == psm_op_unblock && do_store) begin
            pin_verified_ff[gi] <= 1'b1;
          end else if (session_clr) begin
            pin_verified_ff[gi] <= 1'b0;
          end
        end
      end
      assign nv_image_out[gi*8 +: 8] = {pin_blocked_ff[gi], pin_enabled_ff[gi],
                                        puk_cnt_ff[gi], pin_cnt_ff[gi]};
      // disabled grants (blocked or not) unless it is the active substitute pin; enabled needs verification and no block
      assign access_granted[gi] = (!pin_enabled_ff[gi] &&
                                   !(subst_active_ff && subst_pin_ff == `PSM_IDX_W'(gi))) ||
                                  (pin_enabled_ff[gi] && !pin_blocked_ff[gi] &&
                                   pin_verified_ff[gi]);
    end
  endgenerate

  assign any_disabled = ~&pin_enabled_ff;

  // substitute key usage qualifier
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      subst_usage_ff  <= `PSM_USE_NONE;
      subst_ref_ff    <= 5'h00;
      subst_pin_ff    <= '0;
      subst_active_ff <= 1'b0;
    end else if (clk_en && exec_ok && sw_calc == `PSM_SW_OK) begin
      if (op_ff == psm_op_disable && p1_ff[`PSM_P1_SUBST_BIT]) begin
        subst_usage_ff  <= `PSM_USE_SUBST;
        subst_ref_ff    <= p1_ff[`PSM_REF_MSB:`PSM_REF_LSB];
        subst_pin_ff    <= idx_ff;
        subst_active_ff <= 1'b1;
      end else if (op_ff == psm_op_enable && subst_active_ff && subst_pin_ff == idx_ff) begin
        subst_usage_ff  <= `PSM_USE_NONE;
        subst_active_ff <= 1'b0;
      end
    end
  end

  // response and security environment pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_sw_ff    <= 16'h0000;
      se_reeval_ff <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_ff <= (state_ff == psm_exec);
      se_reeval_ff <= exec_ok && sw_calc == `PSM_SW_OK &&
                      op_ff != psm_op_unblock;
      if (state_ff == psm_exec) begin
        rsp_sw_ff <= sw_calc;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/psm_top_monitor.sv */
// assertion checker on the pin state manager ports
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_top_monitor (
  input wire logic                     clk_sys,
  input wire logic                     sys_rst,
  input wire logic                     clk_en,
  input wire logic                     cmd_valid,
  input wire logic                     cmd_ready,
  input wire logic                     nv_load,
  input wire logic                     rsp_valid_ff,
  input wire logic [15:0]              rsp_sw_ff,
  input wire logic [`PSM_NUM_PINS-1:0] pin_enabled_ff,
  input wire logic [`PSM_NUM_PINS-1:0] pin_blocked_ff,
  input wire logic [`PSM_NUM_PINS-1:0] puk_blocked_ff,
  input wire logic [`PSM_NUM_PINS-1:0] access_granted,
  input wire logic                     any_disabled,
  input wire logic [7:0]               subst_usage_ff,
  input wire logic                     subst_active_ff,
  input wire logic                     se_reeval_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_ANSWER_LAT: assert property (cmd_valid && cmd_ready && clk_en |-> ##4 rsp_valid_ff)
    else $error("answer not four cycles after the command was taken");
  AST_RSP_PULSE: assert property (rsp_valid_ff |=> !rsp_valid_ff && cmd_ready)
    else $error("answer pulse not single or ready not back");
  AST_SW_HOLD: assert property (!rsp_valid_ff && !$past(sys_rst) |-> $stable(rsp_sw_ff))
    else $error("status word moved without an answer");
  AST_REEVAL: assert property (se_reeval_ff |-> rsp_valid_ff && rsp_sw_ff == `PSM_SW_OK)
    else $error("re-evaluation pulse without a successful answer");
  AST_SUBST_ON: assert property (subst_active_ff |-> subst_usage_ff == `PSM_USE_SUBST)
    else $error("substitute active but usage qualifier not 08");
  AST_SUBST_OFF: assert property (!subst_active_ff |-> subst_usage_ff == `PSM_USE_NONE)
    else $error("no substitute but usage qualifier not 00");
  AST_BLK_DENY: assert property ((pin_blocked_ff & pin_enabled_ff & access_granted) == '0)
    else $error("blocked enabled pin grants access");
  AST_ANY_DIS: assert property (any_disabled == |(~pin_enabled_ff))
    else $error("any-disabled flag disagrees with pin states");
  AST_PUK_STICKY: assert property (!$past(sys_rst) && !$past(nv_load)
    |-> (puk_blocked_ff & $past(puk_blocked_ff)) == $past(puk_blocked_ff))
    else $error("blocked unblock code was released");
  AST_STATE_QUIET: assert property (!rsp_valid_ff && !$past(sys_rst) && !$past(nv_load)
    |-> $stable(pin_blocked_ff) && $stable(pin_enabled_ff))
    else $error("pin state changed outside an answer");
  COV_REEVAL: cover property (se_reeval_ff);
  COV_SUBST: cover property (subst_active_ff);
  COV_PUK_BLK: cover property ($rose(puk_blocked_ff[2]));
endmodule
bind psm_top psm_top_monitor psm_top_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .nv_load(nv_load),
  .rsp_valid_ff(rsp_valid_ff), .rsp_sw_ff(rsp_sw_ff), .pin_enabled_ff(pin_enabled_ff),
  .pin_blocked_ff(pin_blocked_ff), .puk_blocked_ff(puk_blocked_ff),
  .access_granted(access_granted), .any_disabled(any_disabled),
  .subst_usage_ff(subst_usage_ff), .subst_active_ff(subst_active_ff),
  .se_reeval_ff(se_reeval_ff));
`default_nettype wire

/* File: bench/psm_terminal.sv */
// terminal model issuing pin commands to the card
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_terminal
  import psm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              cmd_ready,
  input  wire logic              rsp_valid_ff,
  input  wire logic [15:0]       rsp_sw_ff,
  output var logic               cmd_valid,
  output var psm_op_t            cmd_op,
  output var logic [7:0]         cmd_p1,
  output var logic [7:0]         cmd_p2,
  output var logic [7:0]         cmd_lc,
  output var logic [`PSM_PIN_W-1:0] cmd_data_a,
  output var logic [`PSM_PIN_W-1:0] cmd_data_b
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = psm_op_disable;
    cmd_p1 = 8'h00;
    cmd_p2 = 8'h00;
    cmd_lc = 8'h00;
    cmd_data_a = 64'h0;
    cmd_data_b = 64'h0;
  end
  // hold the request until taken, then wait a bounded time for the answer
  task automatic send(input psm_op_t op, input logic [7:0] p1, p2, lc,
                      input logic [63:0] a, b, output logic [15:0] sw);
    sw = 16'hFFFF;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_p1 <= p1;
    cmd_p2 <= p2;
    cmd_lc <= lc;
    cmd_data_a <= (lc == `PSM_LC_EMPTY) ? ~cmd_data_a : a;
    cmd_data_b <= (lc == `PSM_LC_UNBLK) ? b : ~cmd_data_b;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (rsp_valid_ff === 1'b1) begin
        sw = rsp_sw_ff;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/pin_state_manager_bench.sv */
// self-checking bench for the pin state manager
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module pin_state_manager_bench
  import psm_pkg::*;
;
  localparam logic [63:0] PIN1 = {8{8'h31}};
  localparam logic [63:0] BAD1 = PIN1 ^ 64'hFF00000000000000;
  localparam logic [63:0] PUK1 = {8{8'h35}};
  localparam logic [63:0] PUK2 = {8{8'h36}};
  localparam logic [63:0] NEWP = 64'h0123456789ABCDEF;
  logic        clk_sys, sys_rst, pin_wr_en, cmd_valid, cmd_ready, rsp_valid_ff;
  logic        any_disabled, subst_active_ff, se_reeval_ff, nv_load;
  logic [2:0]  pin_wr_addr;
  logic [63:0] pin_wr_data, cmd_data_a, cmd_data_b;
  logic [7:0]  cmd_p1, cmd_p2, cmd_lc, subst_usage_ff;
  logic [31:0] nv_image_out, nv_image_in;
  logic [15:0] rsp_sw_ff;
  logic [3:0]  pin_enabled_ff, pin_blocked_ff, puk_blocked_ff, pin_verified_ff, access_granted;
  logic [4:0]  subst_ref_ff;
  logic [1:0]  subst_pin_ff;
  psm_op_t     cmd_op;
  int          err_count, checks_done;

  psm_top psm_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2),
    .cmd_lc(cmd_lc), .cmd_data_a(cmd_data_a), .cmd_data_b(cmd_data_b),
    .cmd_ready(cmd_ready), .nv_load(nv_load), .nv_image_in(nv_image_in),
    .nv_image_out(nv_image_out), .pin_wr_en(pin_wr_en), .pin_wr_addr(pin_wr_addr),
    .pin_wr_data(pin_wr_data), .session_clr(1'b0), .rsp_valid_ff(rsp_valid_ff),
    .rsp_sw_ff(rsp_sw_ff), .pin_enabled_ff(pin_enabled_ff), .pin_blocked_ff(pin_blocked_ff),
    .puk_blocked_ff(puk_blocked_ff), .pin_verified_ff(pin_verified_ff),
    .access_granted(access_granted), .any_disabled(any_disabled),
    .subst_usage_ff(subst_usage_ff), .subst_ref_ff(subst_ref_ff), .subst_pin_ff(subst_pin_ff),
    .subst_active_ff(subst_active_ff), .se_reeval_ff(se_reeval_ff));
  psm_terminal psm_terminal_i (.clk_sys(clk_sys), .cmd_ready(cmd_ready),
    .rsp_valid_ff(rsp_valid_ff), .rsp_sw_ff(rsp_sw_ff), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_lc(cmd_lc),
    .cmd_data_a(cmd_data_a), .cmd_data_b(cmd_data_b));

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input psm_op_t op, input logic [7:0] p1, p2, lc,
                     input logic [63:0] a, b, input logic [15:0] exp);
    logic [15:0] sw;
    psm_terminal_i.send(op, p1, p2, lc, a, b, sw);
    chk(64'(sw), 64'(exp));
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // per pin nv byte: blocked, enabled, unblock count, pin count
  task automatic t_reset();
    chk(64'(nv_image_out), 64'({4{8'h6B}}));
    chk(64'({pin_enabled_ff, pin_blocked_ff, puk_blocked_ff, subst_usage_ff}), 64'h0F0000);
  endtask
  task automatic t_dis_en();
    cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, BAD1, 64'h0, 16'h63C2);
    chk(64'(nv_image_out[15:8]), 64'h6A);
    cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, PIN1, 64'h0, 16'h9000);
    chk(64'({nv_image_out[15:8], access_granted[1], any_disabled}), 64'hAF);
    cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, PIN1, 64'h0, 16'h6985);
    cmd(psm_op_enable, 8'h00, 8'h01, 8'h08, BAD1, 64'h0, 16'h63C2);
    chk(64'(pin_enabled_ff[1]), 64'h0);
    cmd(psm_op_enable, 8'h00, 8'h01, 8'h08, PIN1, 64'h0, 16'h9000);
    chk(64'(nv_image_out[15:8]), 64'h6B);
    cmd(psm_op_enable, 8'h00, 8'h01, 8'h08, PIN1, 64'h0, 16'h6985);
  endtask
  task automatic t_params();
    logic [7:0]  p1s [8] = '{8'h01, 8'h40, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    logic [7:0]  p2s [8] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h05, 8'h01, 8'h01, 8'h21};
    logic [7:0]  lcs [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h08, 8'h08};
    logic [15:0] sws [8] = '{16'h6A86, 16'h6A86, 16'h6A86, 16'h6A88, 16'h6A88, 16'h6700,
                             16'h6A86, 16'h6A88};
    for (int i = 0; i < 8; i++)
      cmd(psm_op_disable, p1s[i], p2s[i], lcs[i], PIN1, 64'h0, sws[i]);
    chk(64'(nv_image_out[15:8]), 64'h6B);
  endtask
  task automatic t_subst();
    cmd(psm_op_disable, 8'h82, 8'h81, 8'h08, PIN1, 64'h0, 16'h9000);
    chk(64'({subst_active_ff, subst_usage_ff, subst_ref_ff, subst_pin_ff,
              access_granted[1]}), 64'h10812);
    cmd(psm_op_enable, 8'h00, 8'h81, 8'h08, PIN1, 64'h0, 16'h9000);
    chk(64'({subst_active_ff, subst_usage_ff}), 64'h0);
  endtask
  task automatic t_unblock();
    for (int i = 0; i < 3; i++)
      cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, BAD1, 64'h0, i < 2 ? 16'(16'h63C2 - i) : 16'h6983);
    chk(64'({pin_blocked_ff[1], pin_enabled_ff[1], access_granted[1]}), 64'h6);
    cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, PIN1, 64'h0, 16'h6985);
    cmd(psm_op_unblock, 8'h00, 8'h01, 8'h10, PUK2, NEWP, 16'h63C9);
    chk(64'(nv_image_out[15:8]), 64'hE4);
    cmd(psm_op_unblock, 8'h00, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63C9);
    cmd(psm_op_unblock, 8'h00, 8'h01, 8'h10, PUK1, NEWP, 16'h9000);
    chk(64'({nv_image_out[15:8], pin_verified_ff[1]}), 64'hD7);
    cmd(psm_op_disable, 8'h00, 8'h01, 8'h08, NEWP, 64'h0, 16'h9000);
    cmd(psm_op_enable, 8'h00, 8'h01, 8'h08, NEWP, 64'h0, 16'h9000);
  endtask
  task automatic t_puk_exhaust();
    for (int i = 0; i < 10; i++)
      cmd(psm_op_unblock, 8'h00, 8'h02, 8'h10, PUK1, NEWP, 16'(16'h63C9 - i));
    chk(64'(puk_blocked_ff[2]), 64'h1);
    cmd(psm_op_unblock, 8'h00, 8'h02, 8'h10, PUK2, NEWP, 16'h6983);
    cmd(psm_op_unblock, 8'h00, 8'h02, 8'h00, 64'h0, 64'h0, 16'h63C0);
    chk(64'(nv_image_out[23:16]), 64'h43);
  endtask
  // load a stored image for pin 3: disabled, one pin try, five unblock tries
  task automatic t_nv();
    nv_image_in <= {8'h15, nv_image_out[23:0]};
    nv_load <= 1'b1;
    @(posedge clk_sys);
    nv_load <= 1'b0;
    cmd(psm_op_unblock, 8'h00, 8'h03, 8'h00, 64'h0, 64'h0, 16'h63C5);
    chk(64'({nv_image_out[31:24], access_granted[3]}), 64'h2B);
    cmd(psm_op_enable, 8'h00, 8'h03, 8'h08, BAD1, 64'h0, 16'h6983);
    chk(64'({nv_image_out[31:24], access_granted[3]}), 64'h1A8);
  endtask

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    pin_wr_en = 1'b0;
    pin_wr_addr = 3'h0;
    pin_wr_data = 64'h0;
    nv_load = 1'b0;
    nv_image_in = 32'h0;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // provision pins 0..3 and unblock codes 4..7
    for (int i = 0; i < 8; i++) begin
      pin_wr_en <= 1'b1;
      pin_wr_addr <= 3'(i);
      pin_wr_data <= {8{8'(8'h30 + i)}};
      @(posedge clk_sys);
    end
    pin_wr_en <= 1'b0;
    t_reset();
    t_dis_en();
    t_params();
    t_subst();
    t_unblock();
    t_puk_exhaust();
    t_nv();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    $display("mismatch at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
